// ==== hw/sst_pkg.sv ====
// Shared constants for the stepper step translator
package sst_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 40;
    // Glitch filter: a level must stand this long before it is accepted
    localparam int unsigned FILT_NS = 200;
    localparam int unsigned FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************************
    // Sequence position
    // ****************************************************************
    // 64 sixteenth-step positions per electrical cycle
    localparam int unsigned POS_W = 6;
    localparam logic [5:0] POS_HOME = 6'h00;
    // Both phases at equal current when the low four bits are zero
    localparam logic [3:0] POS_TWO_PHASE = 4'h0;
    localparam logic [5:0] GRID_FULL = 6'h10;
    localparam logic [5:0] GRID_HALF = 6'h08;
    localparam logic [5:0] GRID_QUARTER = 6'h04;
    localparam logic [5:0] GRID_EIGHTH = 6'h02;
    localparam logic [5:0] GRID_SIXTEENTH = 6'h01;
    localparam logic [5:0] OFS_EQUAL = 6'h00;
    localparam logic [5:0] OFS_FULL_CUR = 6'h08;

    // ****************************************************************
    // Step mode codes {bit3, bit2, bit1}
    // ****************************************************************
    localparam logic [2:0] MODE_FULL_EQ = 3'h0;
    localparam logic [2:0] MODE_FULL_FC = 3'h1;
    localparam logic [2:0] MODE_HALF = 3'h2;
    localparam logic [2:0] MODE_HALF_FC = 3'h3;
    localparam logic [2:0] MODE_QUARTER = 3'h4;
    localparam logic [2:0] MODE_EIGHTH = 3'h5;
    localparam logic [2:0] MODE_SIXTEENTH = 3'h6;
    localparam logic [2:0] MODE_STANDBY = 3'h7;

    // ****************************************************************
    // Filtered input vector positions
    // ****************************************************************
    localparam int unsigned IN_STEP = 0;
    localparam int unsigned IN_DIR = 1;
    localparam int unsigned IN_M1 = 2;
    localparam int unsigned IN_M2 = 3;
    localparam int unsigned IN_M3 = 4;
    localparam int unsigned IN_SYNC = 5;
    localparam int unsigned IN_COAST = 6;
    localparam int unsigned IN_FAULT = 7;
    localparam int unsigned IN_NUM = 8;

    // ****************************************************************
    // APB register map
    // ****************************************************************
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CONTROL = 8'h04;
    localparam logic [7:0] REG_STEP_COUNT = 8'h08;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    // CONTROL fields
    localparam int unsigned CTL_SOFT_COAST = 0;
    localparam int unsigned CTL_SOFT_STEP = 1;
    // STATUS fields
    localparam int unsigned ST_POS_LSB = 0;
    localparam int unsigned ST_MODE_LSB = 8;
    localparam int unsigned ST_DIR = 11;
    localparam int unsigned ST_STAGE_ON = 12;
    localparam int unsigned ST_MONITOR = 13;
    localparam int unsigned ST_PROTECT = 14;
    localparam int unsigned ST_STANDBY = 15;
    localparam int unsigned ST_COAST = 16;
    localparam int unsigned ST_SYNC_CHOP = 17;

endpackage : sst_pkg

// ==== hw/sst_input_filter.sv ====
// Two-flop synchroniser and stable-level glitch filter for one input
`timescale 1ns/100ps
module sst_input_filter #(
    parameter int unsigned FILT_CYC = 5
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // Raw and filtered level
    input wire logic i_raw,
    output logic o_level
);
    logic meta_q;
    logic sync_q;
    logic [7:0] cnt_q;

    always_ff @(posedge i_mclk)
    begin
        meta_q <= i_raw;
        sync_q <= meta_q;
    end

    // Level is accepted only after standing FILT_CYC cycles
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            cnt_q <= 8'h00;
            o_level <= 1'b0;
        end
        else if (sync_q == o_level)
        begin
            cnt_q <= 8'h00;
        end
        else if (cnt_q >= 8'(FILT_CYC - 1))
        begin
            cnt_q <= 8'h00;
            o_level <= sync_q;
        end
        else
        begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

endmodule : sst_input_filter

// ==== hw/sst_translator.sv ====
// Step translator and sequencer for a two-phase unipolar stepper driver
`timescale 1ns/100ps
module sst_translator #(
    parameter bit MICROSTEP = 1'b1,
    parameter bit PROTECTION = 1'b1,
    parameter int unsigned FILT_CYC = sst_pkg::FILT_CYC
) (
    // Clock and system reset (logic supply power-on)
    input wire logic i_mclk,
    input wire logic i_reset,
    // Home reset pin, asynchronous
    input wire logic i_home_reset,
    // Step interface from the controller
    input wire logic i_step_clock,
    input wire logic i_direction,
    input wire logic i_step_mode_bit1,
    input wire logic i_step_mode_bit2,
    input wire logic i_step_mode_bit3,
    input wire logic i_sync_chop,
    input wire logic i_reference_coast_input,
    // Protection comparator trip
    input wire logic i_overcurrent,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Translator outputs
    output logic [5:0] o_position,
    output logic o_stage_enable,
    output logic o_sync_chop_active,
    output logic o_two_phase_monitor,
    output logic o_protect_flag
);

    // ****************************************************************
    // Input synchronisation and filtering
    // ****************************************************************
    logic [sst_pkg::IN_NUM-1:0] raw_in;
    logic [sst_pkg::IN_NUM-1:0] flt_in;

    always_comb
    begin
        raw_in = '0;
        raw_in[sst_pkg::IN_STEP] = i_step_clock;
        raw_in[sst_pkg::IN_DIR] = i_direction;
        raw_in[sst_pkg::IN_M1] = i_step_mode_bit1;
        raw_in[sst_pkg::IN_M2] = i_step_mode_bit2;
        raw_in[sst_pkg::IN_M3] = i_step_mode_bit3;
        raw_in[sst_pkg::IN_SYNC] = i_sync_chop;
        raw_in[sst_pkg::IN_COAST] = i_reference_coast_input;
        raw_in[sst_pkg::IN_FAULT] = i_overcurrent;
    end

    genvar gi;
    generate
        for (gi = 0; gi < sst_pkg::IN_NUM; gi++)
        begin : g_filt
            sst_input_filter #(
                .FILT_CYC(FILT_CYC)
            ) u_filt (
                .i_mclk(i_mclk),
                .i_reset(i_reset),
                .i_raw(raw_in[gi]),
                .o_level(flt_in[gi])
            );
        end
    endgenerate

    logic step_q;
    logic step_rise;
    logic [2:0] mode_in;
    logic coast;
    logic standby;

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            step_q <= 1'b0;
        end
        else
        begin
            step_q <= flt_in[sst_pkg::IN_STEP];
        end
    end

    assign step_rise = flt_in[sst_pkg::IN_STEP] & ~step_q;
    assign mode_in = {flt_in[sst_pkg::IN_M3], flt_in[sst_pkg::IN_M2], flt_in[sst_pkg::IN_M1]};
    assign coast = flt_in[sst_pkg::IN_COAST];
    // Upper codes are standby on full/half parts
    assign standby = (mode_in == sst_pkg::MODE_STANDBY) | (~MICROSTEP & mode_in[2]);

    // ****************************************************************
    // APB registers
    // ****************************************************************
    logic [31:0] control_q;
    logic soft_step_q;
    logic [31:0] step_count_q;
    logic apb_wr;
    logic [31:0] status;

    assign apb_wr = psel & penable & pwrite;
    assign pready = 1'b1;

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            control_q <= sst_pkg::CONTROL_RESET;
            soft_step_q <= 1'b0;
        end
        else
        begin
            soft_step_q <= 1'b0;
            if (apb_wr && paddr == sst_pkg::REG_CONTROL)
            begin
                control_q <= pwdata & 32'h0000_0001;
                soft_step_q <= pwdata[sst_pkg::CTL_SOFT_STEP];
            end
        end
    end

    // ****************************************************************
    // Step sequencing
    // ****************************************************************
    logic [5:0] pos_q;
    logic [5:0] pos_d;
    logic dir_q;
    logic [2:0] mode_q;
    logic step_evt;
    logic [5:0] grid;
    logic [5:0] ofs;
    logic [5:0] rel;
    logic [5:0] mask;

    // Frozen in standby; steps still run while coasting
    assign step_evt = (step_rise | soft_step_q) & ~standby;

    // Grid size and offset of the newly sampled mode
    always_comb
    begin
        grid = sst_pkg::GRID_FULL;
        ofs = sst_pkg::OFS_EQUAL;
        unique case (mode_in)
            sst_pkg::MODE_FULL_EQ:
            begin
                grid = sst_pkg::GRID_FULL;
            end
            sst_pkg::MODE_FULL_FC:
            begin
                grid = sst_pkg::GRID_FULL;
                ofs = sst_pkg::OFS_FULL_CUR;
            end
            sst_pkg::MODE_HALF, sst_pkg::MODE_HALF_FC:
            begin
                grid = sst_pkg::GRID_HALF;
            end
            sst_pkg::MODE_QUARTER:
            begin
                grid = sst_pkg::GRID_QUARTER;
            end
            sst_pkg::MODE_EIGHTH:
            begin
                grid = sst_pkg::GRID_EIGHTH;
            end
            sst_pkg::MODE_SIXTEENTH, sst_pkg::MODE_STANDBY:
            begin
                grid = sst_pkg::GRID_SIXTEENTH;
            end
        endcase
    end

    // Off-grid positions left by the old mode snap to the new grid
    always_comb
    begin
        rel = pos_q - ofs;
        mask = grid - 6'h01;
        if ((rel & mask) == 6'h00)
        begin
            if (flt_in[sst_pkg::IN_DIR])
            begin
                pos_d = pos_q - grid;
            end
            else
            begin
                pos_d = pos_q + grid;
            end
        end
        else if (flt_in[sst_pkg::IN_DIR])
        begin
            pos_d = (rel & ~mask) + ofs;
        end
        else
        begin
            pos_d = (rel | mask) + 6'h01 + ofs;
        end
    end

    // Position returns home at once on the home reset pin
    always_ff @(posedge i_mclk or posedge i_home_reset)
    begin
        if (i_home_reset)
        begin
            pos_q <= sst_pkg::POS_HOME;
        end
        else if (i_reset)
        begin
            pos_q <= sst_pkg::POS_HOME;
        end
        else if (step_evt)
        begin
            pos_q <= pos_d;
        end
    end

    // Direction and mode as applied at the last accepted step
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            dir_q <= 1'b0;
            mode_q <= sst_pkg::MODE_FULL_EQ;
        end
        else if (step_evt)
        begin
            dir_q <= flt_in[sst_pkg::IN_DIR];
            mode_q <= mode_in;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            step_count_q <= 32'h0000_0000;
        end
        else if (step_evt)
        begin
            step_count_q <= step_count_q + 32'h0000_0001;
        end
    end

    // ****************************************************************
    // Protection latch
    // ****************************************************************
    logic prot_q;

    // Cleared only by the power-on reset, never by the home reset pin
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            prot_q <= 1'b0;
        end
        else if (PROTECTION && flt_in[sst_pkg::IN_FAULT])
        begin
            prot_q <= 1'b1;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    logic at_two_phase;
    logic stage_on;

    assign at_two_phase = (pos_q[3:0] == sst_pkg::POS_TWO_PHASE);
    assign stage_on = ~coast & ~standby & ~prot_q & ~flt_in[sst_pkg::IN_FAULT]
        & ~control_q[sst_pkg::CTL_SOFT_COAST];

    always_ff @(posedge i_mclk or posedge i_home_reset)
    begin
        if (i_home_reset)
        begin
            o_stage_enable <= 1'b0;
        end
        else if (i_reset)
        begin
            o_stage_enable <= 1'b0;
        end
        else
        begin
            o_stage_enable <= stage_on;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_two_phase_monitor <= 1'b1;
            o_sync_chop_active <= 1'b0;
            o_protect_flag <= 1'b0;
        end
        else
        begin
            o_two_phase_monitor <= at_two_phase;
            o_sync_chop_active <= flt_in[sst_pkg::IN_SYNC] & at_two_phase;
            o_protect_flag <= prot_q;
        end
    end

    assign o_position = pos_q;

    // ****************************************************************
    // APB read path
    // ****************************************************************
    always_comb
    begin
        status = 32'h0000_0000;
        status[sst_pkg::ST_POS_LSB +: 6] = pos_q;
        status[sst_pkg::ST_MODE_LSB +: 3] = mode_q;
        status[sst_pkg::ST_DIR] = dir_q;
        status[sst_pkg::ST_STAGE_ON] = o_stage_enable;
        status[sst_pkg::ST_MONITOR] = o_two_phase_monitor;
        status[sst_pkg::ST_PROTECT] = prot_q;
        status[sst_pkg::ST_STANDBY] = standby;
        status[sst_pkg::ST_COAST] = coast;
        status[sst_pkg::ST_SYNC_CHOP] = o_sync_chop_active;
    end

    always_comb
    begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (psel && penable)
        begin
            unique case (paddr)
                sst_pkg::REG_STATUS:
                begin
                    prdata = pwrite ? 32'h0000_0000 : status;
                end
                sst_pkg::REG_CONTROL:
                begin
                    prdata = pwrite ? 32'h0000_0000 : control_q;
                end
                sst_pkg::REG_STEP_COUNT:
                begin
                    prdata = pwrite ? 32'h0000_0000 : step_count_q;
                end
                default:
                begin
                    pslverr = 1'b1;
                end
            endcase
        end
    end

endmodule : sst_translator

// ==== tb/sst_translator_chk.sv ====
// Port checker for the stepper step translator
`timescale 1ns/100ps
module sst_translator_chk #(
    parameter int unsigned FILT_CYC = 5
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // Controller pins
    input wire logic i_home_reset,
    input wire logic i_step_mode_bit1,
    input wire logic i_step_mode_bit2,
    input wire logic i_step_mode_bit3,
    input wire logic i_reference_coast_input,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Translator outputs
    input wire logic [5:0] o_position,
    input wire logic o_stage_enable,
    input wire logic o_sync_chop_active,
    input wire logic o_two_phase_monitor,
    input wire logic o_protect_flag
);
    // ****************************************************************
    // Run lengths of settled pin levels
    // ****************************************************************
    logic [7:0] coast_run_q;
    logic [7:0] sleep_run_q;
    always_ff @(posedge i_mclk)
    begin
        if (i_reset || !i_reference_coast_input)
            coast_run_q <= 8'h00;
        else if (coast_run_q != 8'hff)
            coast_run_q <= coast_run_q + 8'h01;
    end
    always_ff @(posedge i_mclk)
    begin
        if (i_reset || !(i_step_mode_bit1 && i_step_mode_bit2 && i_step_mode_bit3))
            sleep_run_q <= 8'h00;
        else if (sleep_run_q != 8'hff)
            sleep_run_q <= sleep_run_q + 8'h01;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    a_home_clears: assert property (i_home_reset |->
        o_position == 6'h00 && !o_stage_enable)
        else $error("home reset left position or stages active");
    a_monitor_tracks: assert property (
        o_two_phase_monitor == ($past(o_position[3:0]) == 4'h0))
        else $error("two phase monitor does not follow position");
    a_sync_two_phase: assert property (o_sync_chop_active |-> o_two_phase_monitor)
        else $error("synchronous chopping away from two phase position");
    a_flag_latched: assert property (o_protect_flag |=> o_protect_flag)
        else $error("protection flag released");
    a_flag_stages_off: assert property (o_protect_flag |=> !o_stage_enable)
        else $error("stages on while protected");
    a_coast_stages_off: assert property (
        coast_run_q > 8'(FILT_CYC + 4) |-> !o_stage_enable)
        else $error("stages on while coasting");
    a_sleep_freezes: assert property (disable iff (i_reset || i_home_reset)
        sleep_run_q > 8'(FILT_CYC + 4) |=> $stable(o_position) && !o_stage_enable)
        else $error("deep standby moved position or left stages on");
    a_apb_answer: assert property (psel && penable |-> pready
        && (pslverr == !(paddr inside {8'h00, 8'h04, 8'h08})))
        else $error("APB answer or error flag wrong");
    c_monitor_rise: cover property ($rose(o_two_phase_monitor));
    c_protect_trip: cover property ($rose(o_protect_flag));
    c_sync_active: cover property (o_sync_chop_active);
endmodule : sst_translator_chk

bind sst_translator sst_translator_chk #(.FILT_CYC(FILT_CYC)) i_sst_translator_chk (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_home_reset(i_home_reset),
    .i_step_mode_bit1(i_step_mode_bit1), .i_step_mode_bit2(i_step_mode_bit2),
    .i_step_mode_bit3(i_step_mode_bit3), .i_reference_coast_input(i_reference_coast_input),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .o_position(o_position), .o_stage_enable(o_stage_enable),
    .o_sync_chop_active(o_sync_chop_active), .o_two_phase_monitor(o_two_phase_monitor),
    .o_protect_flag(o_protect_flag)
);

// ==== tb/sst_ctrl_model.sv ====
// Behavioural controller that drives the translator pins
`timescale 1ns/100ps
module sst_ctrl_model (
    // Clock
    input wire logic i_mclk,
    // Pin levels
    output logic o_step_clock,
    output logic o_direction,
    output logic o_step_mode_bit1,
    output logic o_step_mode_bit2,
    output logic o_step_mode_bit3,
    output logic o_sync_chop,
    output logic o_reference_coast_input
);
    // 1 us setup before the rising step edge
    localparam int unsigned SETUP_CYC = 25;
    initial
    begin
        o_step_clock = 1'b0;
        o_direction = 1'b0;
        {o_step_mode_bit3, o_step_mode_bit2, o_step_mode_bit1} = 3'h0;
        o_sync_chop = 1'b0;
        o_reference_coast_input = 1'b0;
    end
    // A hold under 50 cycles is only used to send a deliberate glitch
    task automatic do_step(input logic dir, input logic [2:0] mode, input int unsigned hold);
        @(posedge i_mclk);
        o_direction <= dir;
        {o_step_mode_bit3, o_step_mode_bit2, o_step_mode_bit1} <= mode;
        repeat (SETUP_CYC) @(posedge i_mclk);
        o_step_clock <= 1'b1;
        repeat (hold) @(posedge i_mclk);
        o_step_clock <= 1'b0;
        repeat (hold) @(posedge i_mclk);
    endtask : do_step
    // Caller raises sync only at the two phase position
    task automatic set_sync(input logic v);
        @(posedge i_mclk);
        o_sync_chop <= v;
    endtask : set_sync
    task automatic set_coast(input logic v);
        @(posedge i_mclk);
        o_reference_coast_input <= v;
    endtask : set_coast
endmodule : sst_ctrl_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the stepper step translator
`timescale 1ns/100ps
`define CHK(name, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("unexpected %s: expected %0h, seen %0h", name, exp, got); \
        end \
    end
module tb_top;
    localparam int unsigned PULSE = 50;
    localparam int LIMIT = 12000;
    logic i_mclk = 1'b0;
    logic i_reset = 1'b1;
    logic i_home_reset = 1'b0;
    logic i_overcurrent = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic i_step_clock, i_direction, i_step_mode_bit1, i_step_mode_bit2, i_step_mode_bit3;
    logic i_sync_chop, i_reference_coast_input, pready, pslverr, o_stage_enable;
    logic o_sync_chop_active, o_two_phase_monitor, o_protect_flag;
    logic [31:0] prdata;
    logic [5:0] o_position;
    logic [5:0] exp_pos = 6'h00;
    logic [5:0] seen_pos = 6'h00;
    logic [5:0] exp_now;
    logic [5:0] exp_q[$];
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 41;
    always #20 i_mclk = ~i_mclk;
    sst_ctrl_model i_sst_ctrl_model (.i_mclk(i_mclk), .o_step_clock(i_step_clock),
        .o_direction(i_direction), .o_step_mode_bit1(i_step_mode_bit1),
        .o_step_mode_bit2(i_step_mode_bit2), .o_step_mode_bit3(i_step_mode_bit3),
        .o_sync_chop(i_sync_chop), .o_reference_coast_input(i_reference_coast_input));
    sst_translator #(.FILT_CYC(2)) i_sst_translator (.i_mclk(i_mclk), .i_reset(i_reset),
        .i_home_reset(i_home_reset), .i_step_clock(i_step_clock), .i_direction(i_direction),
        .i_step_mode_bit1(i_step_mode_bit1), .i_step_mode_bit2(i_step_mode_bit2),
        .i_step_mode_bit3(i_step_mode_bit3), .i_sync_chop(i_sync_chop),
        .i_reference_coast_input(i_reference_coast_input), .i_overcurrent(i_overcurrent),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_position(o_position),
        .o_stage_enable(o_stage_enable), .o_sync_chop_active(o_sync_chop_active),
        .o_two_phase_monitor(o_two_phase_monitor), .o_protect_flag(o_protect_flag));
    // ****************************************************************
    // Expected sequence position
    // ****************************************************************
    function automatic logic [5:0] next_pos(input logic [5:0] cur, input logic dir,
        input logic [2:0] mode);
        logic [5:0] grid;
        logic [5:0] p;
        grid = (mode < sst_pkg::MODE_HALF) ? sst_pkg::GRID_FULL
            : (mode < sst_pkg::MODE_QUARTER) ? sst_pkg::GRID_HALF
            : (mode == sst_pkg::MODE_QUARTER) ? sst_pkg::GRID_QUARTER
            : (mode == sst_pkg::MODE_EIGHTH) ? sst_pkg::GRID_EIGHTH : sst_pkg::GRID_SIXTEENTH;
        if (mode == sst_pkg::MODE_STANDBY)
            return cur;
        p = dir ? cur - 6'h01 : cur + 6'h01;
        while (((p - ((mode == sst_pkg::MODE_FULL_FC) ? sst_pkg::OFS_FULL_CUR : 6'h00))
            & (grid - 6'h01)) != 6'h00)
            p = dir ? p - 6'h01 : p + 6'h01;
        return p;
    endfunction : next_pos
    task automatic expect_pos(input logic [5:0] nxt);
        if (nxt != exp_pos)
            exp_q.push_back(nxt);
        exp_pos = nxt;
    endtask : expect_pos
    task automatic step(input logic dir, input logic [2:0] mode, input int unsigned hold);
        expect_pos((hold >= PULSE) ? next_pos(exp_pos, dir, mode) : exp_pos);
        i_sst_ctrl_model.do_step(dir, mode, hold);
    endtask : step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge i_mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        penable <= 1'b1;
        @(posedge i_mclk);
        while (pready !== 1'b1)
            @(posedge i_mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    // ****************************************************************
    // Output watcher and hang guard
    // ****************************************************************
    always @(posedge i_mclk)
    begin
        cycles++;
        if (i_reset)
            seen_pos = 6'h00;
        else if (o_position !== seen_pos)
        begin
            seen_pos = o_position;
            exp_now = (exp_q.size() > 0) ? exp_q.pop_front() : ~o_position;
            `CHK("position", exp_now, seen_pos)
        end
        if (cycles == LIMIT)
        begin
            fail_count++;
            $display("unexpected cycle count: expected below %0d, seen %0d", LIMIT, cycles);
            summarize();
        end
    end
    initial
    begin
        logic [31:0] rd;
        logic err;
        logic d;
        logic [2:0] m;
        repeat (6) @(posedge i_mclk);
        i_reset <= 1'b0;
        repeat (130) @(posedge i_mclk);
        `CHK("stages after reset", 1'b1, o_stage_enable)
        for (int k = 0; k < 14; k++)
            step(k[0], 3'(k >> 1), PULSE);
        for (int k = 0; k < 16; k++)
        begin
            d = 1'($random(seed));
            m = 3'($unsigned($random(seed)) % 7);
            step(d, m, (k % 2 == 0) ? PULSE : PULSE + 30);
        end
        apb(1'b0, sst_pkg::REG_STATUS, 32'h0, rd, err);
        `CHK("status position", exp_pos, rd[5:0])
        `CHK("status mode and dir", {d, m}, rd[11:8])
        `CHK("status monitor", exp_pos[3:0] == 4'h0, rd[13])
        $display("test done: step sequences");
        step(1'b0, sst_pkg::MODE_SIXTEENTH, 1);
        step(1'b0, sst_pkg::MODE_STANDBY, PULSE);
        `CHK("stages in standby", 1'b0, o_stage_enable)
        i_sst_ctrl_model.set_coast(1'b1);
        step(1'b1, sst_pkg::MODE_HALF, PULSE);
        `CHK("stages coasting", 1'b0, o_stage_enable)
        i_sst_ctrl_model.set_coast(1'b0);
        repeat (12) @(posedge i_mclk);
        `CHK("stages after coast", 1'b1, o_stage_enable)
        $display("test done: glitch, standby, coast");
        apb(1'b1, sst_pkg::REG_CONTROL, 32'h0000_0001, rd, err);
        apb(1'b0, sst_pkg::REG_CONTROL, 32'h0, rd, err);
        `CHK("control readback", 32'h0000_0001, rd)
        `CHK("stages soft coast", 1'b0, o_stage_enable)
        apb(1'b1, sst_pkg::REG_CONTROL, 32'h0, rd, err);
        expect_pos(next_pos(exp_pos, i_direction, 3'h2));
        apb(1'b1, sst_pkg::REG_CONTROL, 32'h0000_0002, rd, err);
        apb(1'b0, sst_pkg::REG_CONTROL, 32'h0, rd, err);
        `CHK("control step bit", 32'h0000_0000, rd)
        apb(1'b0, 8'h0c, 32'h0, rd, err);
        `CHK("unmapped error", 2'b10, {err, |rd})
        apb(1'b0, sst_pkg::REG_STEP_COUNT, 32'h0, rd, err);
        `CHK("step count", 32'h0000_0020, rd)
        repeat (12) @(posedge i_mclk);
        $display("test done: registers");
        @(posedge i_mclk);
        i_home_reset <= 1'b1;
        expect_pos(6'h00);
        #1;
        `CHK("home position", sst_pkg::POS_HOME, o_position)
        `CHK("stages in home reset", 1'b0, o_stage_enable)
        repeat (60) @(posedge i_mclk);
        i_home_reset <= 1'b0;
        repeat (130) @(posedge i_mclk);
        `CHK("stages after home", 1'b1, o_stage_enable)
        i_sst_ctrl_model.set_sync(1'b1);
        repeat (12) @(posedge i_mclk);
        `CHK("sync chop at home", 1'b1, o_sync_chop_active)
        i_sst_ctrl_model.set_sync(1'b0);
        $display("test done: home reset and sync");
        i_overcurrent <= 1'b1;
        repeat (20) @(posedge i_mclk);
        i_overcurrent <= 1'b0;
        repeat (20) @(posedge i_mclk);
        `CHK("protection latched", 2'b10, {o_protect_flag, o_stage_enable})
        i_reset <= 1'b1;
        repeat (6) @(posedge i_mclk);
        i_reset <= 1'b0;
        repeat (2) @(posedge i_mclk);
        `CHK("protection after supply", 1'b0, o_protect_flag)
        `CHK("pending positions", 0, exp_q.size())
        $display("test done: protection");
        summarize();
    end
endmodule : tb_top
